// File: dv/cpu_instruction_execute_properties.sv
`include "cpu_exec_defs.vh"
// ***********************************************************
// Checker of command timing and control outputs
// ***********************************************************
module cpu_exec_checker (
  input wire        clk_sys_i,
  input wire        rst_i,
  input wire [3:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        wdt_tick_i,
  input wire [11:0] pc_o,
  input wire        sleeping_o,
  input wire [7:0]  wdt_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] top;
  logic [1:0]  lit;
  logic [1:0]  page;
  wire         acc = avs_write_i && !avs_waitrequest_o;
  wire [4:0]   op  = avs_writedata_i[4:0];
  wire         req = avs_write_i && avs_address_i == `REG_CMD;
  wire         cmd = acc && avs_address_i == `REG_CMD;
  wire         two = cmd && op >= `OP_RETI && op <= `OP_RET;
  // Shadow of stack top, literal and page latch
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      top  <= 12'h000;
      lit  <= 2'h0;
      page <= 2'h0;
    end else if (acc) begin
      if (avs_address_i == `REG_PC) top <= avs_writedata_i[11:0];
      if (avs_address_i == `REG_OPERAND) lit <= avs_writedata_i[1:0];
      if (cmd && op == `OP_PAGE) page <= lit;
    end
  end
  default clocking dc_clk @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  chk_sleep_halt: assert property (
    cmd && op == `OP_SLEEP |-> ##[1:3] sleeping_o)
    else $error("sleep did not halt");
  chk_sleep_wdt: assert property (
    cmd && op == `OP_SLEEP |-> ##[1:3] wdt_count_o == 8'h00)
    else $error("sleep did not clear watchdog");
  chk_irq_ret_pc: assert property (
    cmd && op == `OP_RETI |-> ##[1:3] pc_o == top)
    else $error("irq return pc wrong");
  chk_lit_ret_pc: assert property (
    cmd && op == `OP_RETL |-> ##[1:3] pc_o == top)
    else $error("literal return pc wrong");
  chk_plain_ret_pc: assert property (
    cmd && op == `OP_RET |-> ##[1:3] pc_o == top)
    else $error("return pc wrong");
  chk_tbl_page: assert property (
    cmd && op == `OP_TBL |-> ##[1:3] pc_o[11:10] == page)
    else $error("table jump page bits wrong");
  chk_two_cycle: assert property (
    two ##2 req |-> avs_waitrequest_o)
    else $error("return finished too early");
  chk_one_cycle: assert property (
    cmd && !two ##2 req |-> !avs_waitrequest_o)
    else $error("single cycle command stalled");
  cover property (two ##2 req);
  cover property (cmd && op == `OP_SLEEP);
  cover property (cmd && op == `OP_TBL);
endmodule // cpu_exec_checker

bind cpu_instruction_execute cpu_exec_checker i_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .wdt_tick_i(wdt_tick_i), .pc_o(pc_o), .sleeping_o(sleeping_o),
  .wdt_count_o(wdt_count_o));

// File: dv/tb_cpu_instruction_execute.sv
`include "cpu_exec_defs.vh"
`define CMP(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %0t: got %0h want %0h", $time, g, e); end end
// ***********************************************************
// Bench with a reference model of the core
// ***********************************************************
module tb_cpu_instruction_execute;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic        wdt_tick_i = 1'b0;
  wire  [31:0] avs_readdata_o;
  wire         avs_waitrequest_o;
  wire  [11:0] pc_o;
  wire         sleeping_o;
  wire  [7:0]  wdt_count_o;
  int          bad_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [7:0]  fr [64];
  logic [7:0]  w = 8'h00, r, lit, res;
  logic [5:0]  adr;
  logic        c = 1'b0, dc = 1'b0, z = 1'b0, ci;
  logic [8:0]  s;
  logic [4:0]  h;
  logic [11:0] top;
  logic [31:0] rv;
  logic [4:0]  ops [13] = '{`OP_ORR, `OP_ORI, `OP_STW, `OP_LDI, `OP_MOVE_REGISTER_OP,
    `OP_RLR, `OP_RRR, `OP_SBC, `OP_SUBR, `OP_SUBI, `OP_SWAP, `OP_XORR,
    `OP_XORI};

  cpu_instruction_execute i_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .wdt_tick_i(wdt_tick_i), .pc_o(pc_o), .sleeping_o(sleeping_o),
    .wdt_count_o(wdt_count_o));

  // Clock, watchdog ticks and hang guard
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    wdt_tick_i <= ($urandom % 4) == 0;
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (bad_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Avalon cycles held until waitrequest is low
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    avs_address_i   <= a;
    avs_writedata_i <= v;
    avs_write_i     <= 1'b1;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    avs_address_i <= a;
    avs_read_i    <= 1'b1;
    do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'b0);
    v = avs_readdata_o;
    avs_read_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // Compare working value, flags and file byte with the model
  task automatic chk(input logic f);
    rd(`REG_WORK, rv);
    `CMP(rv[7:0], w)
    rd(`REG_STATUS, rv);
    `CMP(rv[2:0], {z, dc, c})
    if (f) begin
      rd(`REG_FILE, rv);
      `CMP(rv[7:0], fr[adr])
    end
  endtask

  // One data operation through the model
  task automatic step(input logic [4:0] op, input logic dd);
    wr(`REG_OPERAND, {18'h0, adr, lit});
    wr(`REG_WORK, {24'h0, w});
    wr(`REG_FILE, {24'h0, fr[adr]});
    wr(`REG_CMD, {23'h0, dd, 3'h0, op});
    r = fr[adr];
    if (op inside {`OP_ORI, `OP_SUBI, `OP_XORI, `OP_LDI}) begin
      r = lit;
      dd = 1'b0;
    end
    ci = op == `OP_SBC ? c : 1'b1;
    s = r + {1'b0, ~w} + ci;
    h = r[3:0] + {1'b0, ~w[3:0]} + ci;
    case (op)
      `OP_ORR, `OP_ORI:   res = w | r;
      `OP_XORR, `OP_XORI: res = w ^ r;
      `OP_RLR:            res = {r[6:0], c};
      `OP_RRR:            res = {c, r[7:1]};
      `OP_SWAP:           res = {r[3:0], r[7:4]};
      `OP_STW:            res = w;
      `OP_SBC, `OP_SUBR, `OP_SUBI: begin
        res = s[7:0];
        c   = s[8];
        dc  = h[4];
      end
      default:            res = r;
    endcase
    if (op == `OP_RLR) c = r[7];
    if (op == `OP_RRR) c = r[0];
    if (!(op inside {`OP_RLR, `OP_RRR, `OP_SWAP, `OP_STW, `OP_LDI}))
      z = res == 8'h00;
    if (dd || op == `OP_STW) fr[adr] = res;
    else w = res;
    chk(1'b1);
  endtask

  initial begin
    rv = $urandom(32'h3371B241);
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    `CMP(pc_o, 12'h000)
    rd(`REG_STATUS, rv);
    `CMP(rv[7:0], 8'h18)
    // Port control and config round trips
    for (int k = 0; k < 6; k++) begin
      adr = (k < 2) ? 6'(5 + k) : 6'(10 + k);
      lit = 8'($urandom);
      wr(`REG_OPERAND, {18'h0, adr, 8'h00});
      wr(`REG_WORK, {24'h0, lit});
      wr(`REG_CMD, {27'h0, k < 5 ? `OP_PCW : `OP_CFGW});
      wr(`REG_WORK, {24'h0, ~lit});
      wr(`REG_CMD, {27'h0, k < 5 ? `OP_PCR : `OP_CFGR});
      w = lit;
      chk(1'b0);
    end
    // Random data operations
    for (int i = 0; i < 300; i++) begin
      adr = 6'h10 + 6'($urandom % 48);
      lit = 8'($urandom);
      w = 8'($urandom);
      fr[adr] = 8'($urandom);
      step(ops[$urandom % 13], 1'($urandom));
    end
    // Each return, then a table jump right behind it
    for (int k = 0; k < 3; k++) begin
      top = 12'($urandom);
      lit = 8'($urandom);
      wr(`REG_OPERAND, {24'h0, lit});
      wr(`REG_CMD, {27'h0, `OP_PAGE});
      wr(`REG_PC, {20'h0, top});
      wr(`REG_CMD, {27'h0, `OP_RETI + 5'(k)});
      if (k == 1) w = lit;
      s = top[7:0] + w;
      h = top[3:0] + w[3:0];
      wr(`REG_CMD, {27'h0, `OP_TBL});
      c = s[8];
      dc = h[4];
      z = s[7:0] == 8'h00;
      rd(`REG_STATUS, rv);
      `CMP(rv[5], 1'b1)
      `CMP(pc_o, {lit[1:0], top[9:8], s[7:0]})
      chk(1'b0);
    end
    // Sleep entry, then commands wake the core
    repeat (200) @(posedge clk_sys_i);
    wr(`REG_CMD, {27'h0, `OP_SLEEP});
    rd(`REG_STATUS, rv);
    `CMP(rv[6:3], 4'hE)
    `CMP(sleeping_o, 1'b1)
    lit = 8'($urandom);
    wr(`REG_OPERAND, {24'h0, lit});
    wr(`REG_CMD, {27'h0, `OP_LDI});
    wr(`REG_CMD, {27'h0, `OP_LDI});
    w = lit;
    chk(1'b0);
    report_and_stop();
  end
endmodule // tb_cpu_instruction_execute

// File: src/cpu_exec_defs.vh
`ifndef CPU_EXEC_DEFS_VH
`define CPU_EXEC_DEFS_VH
// ***********************************************************
// Register word addresses (Avalon word offsets, one per register)
// ***********************************************************
`define REG_CMD      4'h0
`define REG_OPERAND  4'h1
`define REG_WORK     4'h2
`define REG_STATUS   4'h3
`define REG_PC       4'h4
`define REG_CONFIG   4'h5
`define REG_FILE     4'h6
`define REG_PAGE     4'h7
// Command field positions in REG_CMD
`define CMD_OP_LSB   0
`define CMD_OP_MSB   4
`define CMD_DEST_BIT 8
// Operand field positions in REG_OPERAND
`define OPD_LIT_MSB  7
`define OPD_ADR_LSB  8
`define OPD_ADR_MSB  13
// Status bit positions
`define ST_CARRY     0
`define ST_HALF      1
`define ST_ZERO      2
`define ST_PD_N      3
`define ST_TO_N      4
`define ST_GIE       5
`define ST_SLEEP     6
`define ST_BUSY      7
// Opcodes
`define OP_ORR       5'h00
`define OP_ORI       5'h01
`define OP_PCW       5'h02
`define OP_PCR       5'h03
`define OP_STW       5'h04
`define OP_LDI       5'h05
`define OP_MOVE_REGISTER_OP      5'h06
`define OP_CFGW      5'h07
`define OP_CFGR      5'h08
`define OP_PAGE      5'h09
`define OP_RETI      5'h0A
`define OP_RETL      5'h0B
`define OP_RET       5'h0C
`define OP_RLR       5'h0D
`define OP_RRR       5'h0E
`define OP_SLEEP     5'h0F
`define OP_SBC       5'h10
`define OP_SUBR      5'h11
`define OP_SUBI      5'h12
`define OP_SWAP      5'h13
`define OP_TBL       5'h14
`define OP_XORR      5'h15
`define OP_XORI      5'h16
// Reset values and timing
`define RST_STATUS   8'h18
`define RST_BYTE     8'h00
`define RST_PC       12'h000
`define CYC_ONE      2'h1
`define CYC_TWO      2'h2
`endif

// File: src/cpu_instruction_execute.v
// Summary of operation
// - OR work with file reg, zero flag only, dest bit picks target
// - OR 8-bit literal into work, zero flag only, one cycle
// - Work to port control reg at 0x05-0x06 or 0x0C-0x0E, no flags
// - Port control reg to work, one cycle, flags unchanged
// - Store work into file reg up to 0x3F, no flags, one cycle
// - Load 8-bit literal into work, no flags
// - Move file reg to dest, always update zero flag
// - Config reg written from or read into work, no flags, one cycle
// - Page op loads 2-bit literal into page latch bits 3:2
// - Interrupt return pops stack to PC and sets irq allow, two cycles
// - Return with literal loads work and pops stack, two cycles
// - Plain return pops stack to PC in two cycles, no flags
// - Rotate left through carry to dest, only carry flag changes
// - Rotate right through carry, result to dest
// - Sleep clears watchdog and prescaler, sets TO_n, clears PD_n
// - Subtract with borrow: R plus inverted work plus carry, all flags
// - Subtract work from R, all three flags, dest bit target
// - Swap nibbles of R to dest, no flags
// - Table jump adds work to PC low byte, page bits to PC top
// - XOR work with R to dest, zero flag only, one cycle
// - XOR literal into work, zero flag only
`include "cpu_exec_defs.vh"
module cpu_instruction_execute (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire [3:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  input  wire        wdt_tick_i,
  output wire [11:0] pc_o,
  output wire        sleeping_o,
  output wire [7:0]  wdt_count_o
);

  // ***********************************************************
  // State
  // ***********************************************************
  reg  [7:0]  working_register;
  reg  [7:0]  file_mem [0:63];
  reg  [7:0]  port_control_register [0:15];
  reg  [7:0]  config_reg;
  reg  [3:0]  program_page_latch;
  reg  [11:0] pc;
  reg  [11:0] stack_top;
  reg         carry;
  reg         half_byte_flag;
  reg         zero;
  reg         watchdog_expiry_flag_n;
  reg         sleep_entered_flag_n;
  reg         global_irq_allow;
  reg         sleeping;
  reg  [7:0]  watchdog_counter;
  reg  [7:0]  wdt_prescale;
  reg  [4:0]  cmd_op;
  reg         cmd_dest;
  reg  [7:0]  lit;
  reg  [5:0]  adr;
  reg  [1:0]  busy_cnt;
  reg         rd_ack;
  integer     i;

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_EXEC = 2'd1;
  localparam [1:0] ST_WAIT = 2'd2;
  reg  [1:0]  state;

  // ***********************************************************
  // Datapath
  // ***********************************************************
  wire [7:0] fr = file_mem[adr];
  wire [7:0] sub_a = (cmd_op == `OP_SUBI) ? lit : fr;
  wire       cin = (cmd_op == `OP_SBC) ? carry : 1'b1;
  wire [8:0] diff = {1'b0, sub_a} + {1'b0, ~working_register}
                    + {8'h00, cin};
  wire [4:0] hdiff = {1'b0, sub_a[3:0]} + {1'b0, ~working_register[3:0]}
                     + {4'h0, cin};
  wire [8:0] tsum = {1'b0, pc[7:0]} + {1'b0, working_register};
  wire [4:0] tsum_h = {1'b0, pc[3:0]} + {1'b0, working_register[3:0]};
  wire       port_ok = (adr == 6'h05) || (adr == 6'h06) ||
                       (adr >= 6'h0C && adr <= 6'h0E);

  reg  [7:0] next_res;
  reg        next_res_ok;
  reg        next_zero_upd;

  // Result selection per operation
  always @* begin
    next_res = `RST_BYTE;
    next_res_ok = 1'b1;
    next_zero_upd = 1'b1;
    case (cmd_op)
      `OP_ORR:  next_res = working_register | fr;
      `OP_ORI:  next_res = working_register | lit;
      `OP_MOVE_REGISTER_OP: next_res = fr;
      `OP_RLR: begin
        next_res = {fr[6:0], carry};
        next_zero_upd = 1'b0;
      end
      `OP_RRR: begin
        next_res = {carry, fr[7:1]};
        next_zero_upd = 1'b0;
      end
      `OP_SBC:  next_res = diff[7:0];
      `OP_SUBR: next_res = diff[7:0];
      `OP_SUBI: next_res = diff[7:0];
      `OP_SWAP: begin
        next_res = {fr[3:0], fr[7:4]};
        next_zero_upd = 1'b0;
      end
      `OP_XORR: next_res = working_register ^ fr;
      `OP_XORI: next_res = working_register ^ lit;
      default: begin
        next_res_ok = 1'b0;
        next_zero_upd = 1'b0;
      end
    endcase
  end

  // ***********************************************************
  // Avalon slave
  // ***********************************************************
  wire wr_cmd = avs_write_i && (avs_address_i == `REG_CMD)
                && (state == ST_IDLE);
  // Reads answer one cycle late; every write waits while busy, so an
  // operand or data write is never acknowledged and then dropped
  assign avs_waitrequest_o = (avs_read_i && !rd_ack) ||
    (avs_write_i && state != ST_IDLE);
  assign pc_o = pc;
  assign sleeping_o = sleeping;
  assign wdt_count_o = watchdog_counter;

  // Read data register
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h00000000;
      rd_ack <= 1'b0;
    end else begin
      rd_ack <= avs_read_i && !rd_ack;
      case (avs_address_i)
        `REG_CMD:     avs_readdata_o <= {23'h0, cmd_dest, 3'h0, cmd_op};
        `REG_OPERAND: avs_readdata_o <= {18'h0, adr, lit};
        `REG_WORK:    avs_readdata_o <= {24'h0, working_register};
        `REG_STATUS:  avs_readdata_o <= {24'h0, state != ST_IDLE,
          sleeping, global_irq_allow, watchdog_expiry_flag_n,
          sleep_entered_flag_n, zero, half_byte_flag, carry};
        `REG_PC:      avs_readdata_o <= {20'h0, pc};
        `REG_CONFIG:  avs_readdata_o <= {24'h0, config_reg};
        `REG_FILE:    avs_readdata_o <= {24'h0, fr};
        `REG_PAGE:    avs_readdata_o <= {28'h0, program_page_latch};
        default:      avs_readdata_o <= 32'h00000000;
      endcase
    end
  end

  // ***********************************************************
  // Execution engine
  // ***********************************************************
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      working_register <= `RST_BYTE;
      config_reg <= `RST_BYTE;
      program_page_latch <= 4'h0;
      pc <= `RST_PC;
      stack_top <= `RST_PC;
      carry <= 1'b0;
      half_byte_flag <= 1'b0;
      zero <= 1'b0;
      watchdog_expiry_flag_n <= 1'b1;
      sleep_entered_flag_n <= 1'b1;
      global_irq_allow <= 1'b0;
      sleeping <= 1'b0;
      watchdog_counter <= `RST_BYTE;
      wdt_prescale <= `RST_BYTE;
      cmd_op <= 5'h00;
      cmd_dest <= 1'b0;
      lit <= `RST_BYTE;
      adr <= 6'h00;
      busy_cnt <= 2'h0;
      state <= ST_IDLE;
      for (i = 0; i < 64; i = i + 1)
        file_mem[i] <= `RST_BYTE;
      for (i = 0; i < 16; i = i + 1)
        port_control_register[i] <= `RST_BYTE;
    end else begin
      // Free-running watchdog counter with prescaler
      if (wdt_tick_i) begin
        wdt_prescale <= wdt_prescale + 8'h01;
        if (wdt_prescale == 8'hFF)
          watchdog_counter <= watchdog_counter + 8'h01;
      end
      // Software side register writes
      if (avs_write_i && state == ST_IDLE) begin
        case (avs_address_i)
          `REG_OPERAND: begin
            if (avs_byteenable_i[0]) lit <= avs_writedata_i[7:0];
            if (avs_byteenable_i[1])
              adr <= avs_writedata_i[`OPD_ADR_MSB:`OPD_ADR_LSB];
          end
          `REG_WORK:
            if (avs_byteenable_i[0])
              working_register <= avs_writedata_i[7:0];
          `REG_PC: stack_top <= avs_writedata_i[11:0];
          `REG_FILE:
            if (avs_byteenable_i[0]) file_mem[adr] <= avs_writedata_i[7:0];
          default: ;
        endcase
      end
      case (state)
        ST_IDLE:
          if (wr_cmd) begin
            cmd_op <= avs_writedata_i[`CMD_OP_MSB:`CMD_OP_LSB];
            cmd_dest <= avs_writedata_i[`CMD_DEST_BIT];
            sleeping <= 1'b0;
            state <= ST_EXEC;
          end
        ST_EXEC: begin
          busy_cnt <= `CYC_ONE;
          state <= ST_IDLE;
          // Shared result write-back and zero flag
          if (next_res_ok) begin
            if (cmd_dest && cmd_op != `OP_ORI && cmd_op != `OP_SUBI &&
                cmd_op != `OP_XORI)
              file_mem[adr] <= next_res;
            else
              working_register <= next_res;
          end
          if (next_zero_upd)
            zero <= (next_res == 8'h00);
          case (cmd_op)
            // Illegal port addresses are ignored
            `OP_PCW: if (port_ok)
              port_control_register[adr[3:0]] <=
                working_register;
            `OP_PCR: if (port_ok)
              working_register <=
                port_control_register[adr[3:0]];
            `OP_STW: file_mem[adr] <= working_register;
            `OP_LDI: working_register <= lit;
            `OP_CFGW: config_reg <= working_register;
            `OP_CFGR: working_register <= config_reg;
            `OP_PAGE:
              program_page_latch[3:2] <= lit[1:0];
            `OP_RETI: begin
              pc <= stack_top;
              global_irq_allow <= 1'b1;
              state <= ST_WAIT;
            end
            `OP_RETL: begin
              working_register <= lit;
              pc <= stack_top;
              state <= ST_WAIT;
            end
            `OP_RET: begin
              pc <= stack_top;
              state <= ST_WAIT;
            end
            `OP_RLR: carry <= fr[7];
            `OP_RRR: carry <= fr[0];
            `OP_SLEEP: begin
              watchdog_counter <= `RST_BYTE;
              wdt_prescale <= `RST_BYTE;
              watchdog_expiry_flag_n <= 1'b1;
              sleep_entered_flag_n <= 1'b0;
              sleeping <= 1'b1;
            end
            `OP_SBC, `OP_SUBR, `OP_SUBI: begin
              carry <= diff[8];
              half_byte_flag <= hdiff[4];
            end
            `OP_TBL: begin
              pc <= {program_page_latch[3:2], pc[9:8],
                     tsum[7:0]};
              carry <= tsum[8];
              half_byte_flag <= tsum_h[4];
              zero <= (tsum[7:0] == 8'h00);
            end
            default: ;
          endcase
        end
        ST_WAIT: begin
          busy_cnt <= `CYC_TWO;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // cpu_instruction_execute
